// ==== hw/ext_mem_pkg.sv ====
// constants shared by the external memory bus interface and its bench
// assumes an ahb-lite master with 32-bit data and word-aligned registers
package ext_mem_pkg;

  // printed register offsets are register indices; byte address is four times
  localparam logic [7:0] cfg_one_index = 8'hf5;
  localparam logic [7:0] cfg_two_index = 8'hf6;
  localparam logic [7:0] bus_ctrl_index = 8'hf7;
  localparam logic [7:0] bus_status_index = 8'hf8;
  localparam logic [31:0] cfg_one_addr = {22'h0, cfg_one_index, 2'b00};
  localparam logic [31:0] cfg_two_addr = {22'h0, cfg_two_index, 2'b00};
  localparam logic [31:0] bus_ctrl_addr = {22'h0, bus_ctrl_index, 2'b00};
  localparam logic [31:0] bus_status_addr = {22'h0, bus_status_index, 2'b00};

  // reset values
  localparam logic [7:0] cfg_one_reset = 8'h80;
  localparam logic [7:0] cfg_two_reset = 8'h1f;
  localparam logic [7:0] bus_ctrl_reset = 8'h00;

  // writable bits; bit 7 of cfg_one reads back its reset one
  localparam logic [7:0] cfg_one_wmask = 8'h76;
  localparam logic [7:0] cfg_two_wmask = 8'h7f;
  localparam logic [7:0] bus_ctrl_wmask = 8'h07;

  // cfg_one fields
  localparam int strobe_style_bit = 6;
  localparam int lower_strobe_enable_bit = 5;
  localparam int addr_strobe_pin_alt_bit = 4;
  localparam int pin_toggle_select_bit = 2;
  localparam int drive_strength_bit = 1;

  // cfg_two fields
  localparam int segment_save_enable_bit = 6;
  localparam int page_reg_swap_bit = 5;
  localparam int memory_select_bit = 4;
  localparam int lower_addr_stretch_lsb = 2;
  localparam int upper_addr_stretch_lsb = 0;

  // bus_ctrl fields
  localparam int bus_float_bit = 0;
  localparam int hold_request_enable = 1;
  localparam int ext_wait_enable = 2;

  // bus_status fields
  localparam int status_phase_lsb = 0;
  localparam int status_hold_bit = 2;
  localparam int status_write_bit = 3;
  localparam int status_lower_bit = 4;

  // block select bit of the 22-bit internal address
  localparam int block_select_bit = 21;

  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_t1 = 2'b01,
    ph_t2 = 2'b10,
    ph_hold = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    sel_none = 3'b000,
    sel_cfg_one = 3'b001,
    sel_cfg_two = 3'b010,
    sel_ctrl = 3'b011,
    sel_status = 3'b100
  } reg_sel_t;

endpackage

// ==== hw/external_memory_bus_interface.sv ====
// external memory bus interface: multiplexed address/data port, strobes,
// wait and address stretch, bus hold handshake, ahb-lite register slave
// assumes all pins synchronous to hclk; pads resolve level from enables
//
// Functional notes
// - rw high for read, low write, held
// - rw floats during hold or float bit
// - hold request sampled in t2 when enabled
// - hold request floats all bus pins, stretches
// - hold acknowledge low in hold only, float bit ignored
// - hold disabled at reset, needs pins and enable
// - low port carries address then data
// - high port carries upper address byte
// - wait input adds one cycle per sample
// - wait in t1 stretches address strobe, t2 data
// - strobe style inverts address strobe
// - style one: data strobe is read enable
// - style one: rw pin is write enable
// - lower strobe disabled stays high
// - lower block uses lower strobe, main high
// - address strobe pin alt enables output
// - internal accesses toggle pins only if selected
// - drive strength bit selects output buffers
// - segment save enable exported to core
// - page register swap exported to core
// - lower address stretch, reset three
// - upper address stretch, reset three
// - every cycle has t1 then t2
// - address bit 21 selects memory block
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps

module external_memory_bus_interface
  import ext_mem_pkg::*;
(
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // core access request
  input wire logic req,
  input wire logic req_write,
  input wire logic req_internal,
  input wire logic [21:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic done,
  output logic [7:0] rdata,
  // pin configuration from port logic
  input wire logic hold_pins_alt,
  input wire logic mem_protect,
  // strobes
  output logic address_strobe_out,
  output logic address_strobe_oe,
  output logic data_strobe_out,
  output logic data_strobe_oe,
  output logic lower_block_strobe,
  output logic lower_block_strobe_oe,
  output logic rw_out,
  output logic rw_oe,
  // address and data ports
  input wire logic [7:0] low_port_in,
  output logic [7:0] low_port_out,
  output logic low_port_oe,
  output logic [7:0] high_port_out,
  output logic high_port_oe,
  // wait and hold handshake
  input wire logic wait_n,
  input wire logic hold_request_in_n,
  output logic hold_ack_n,
  // settings used elsewhere in the chip
  output logic drive_strength,
  output logic segment_save_enable,
  output logic page_reg_swap
);

  typedef struct packed {
    phase_t phase;
    logic [2:0] cnt;
    logic acc_write;
    logic acc_lower;
    logic acc_ext;
    logic acc_pins;
    logic [7:0] cfg_one;
    logic [7:0] cfg_two;
    logic [7:0] ctrl;
    logic ahb_wr;
    reg_sel_t ahb_sel;
    logic [31:0] hrdata;
    logic hreadyout;
    logic done;
    logic [7:0] rdata;
    logic as_core;
    logic ds_core;
    logic rw_level;
    logic as_out;
    logic as_oe;
    logic ds_out;
    logic ds2_out;
    logic rw_out;
    logic strobe_oe;
    logic [7:0] p0_out;
    logic p0_drive;
    logic p0_oe;
    logic [7:0] p1_out;
    logic p1_oe;
    logic hold_ack_n;
  } state_t;

  state_t s;
  state_t next_s;

  logic hold_en;
  logic wait_hit;
  logic [1:0] stretch_sel;
  logic released;
  logic style;
  logic [7:0] status_val;
  logic [7:0] read_val;
  reg_sel_t dec_sel;

  always_comb begin
    // hold works only with both pins on their alternate function
    hold_en = s.ctrl[hold_request_enable] && hold_pins_alt;
    wait_hit = s.ctrl[ext_wait_enable] && !wait_n;
    style = s.cfg_one[strobe_style_bit];
    stretch_sel = req_addr[block_select_bit] ?
        s.cfg_two[upper_addr_stretch_lsb +: 2] :
        s.cfg_two[lower_addr_stretch_lsb +: 2];
    status_val = 8'h00;
    status_val[status_phase_lsb +: 2] = s.phase;
    status_val[status_hold_bit] = !s.hold_ack_n;
    status_val[status_write_bit] = s.acc_write;
    status_val[status_lower_bit] = s.acc_lower;
    if (haddr == cfg_one_addr) begin
      dec_sel = sel_cfg_one;
    end else if (haddr == cfg_two_addr) begin
      dec_sel = sel_cfg_two;
    end else if (haddr == bus_ctrl_addr) begin
      dec_sel = sel_ctrl;
    end else if (haddr == bus_status_addr) begin
      dec_sel = sel_status;
    end else begin
      dec_sel = sel_none;
    end
  end

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.hreadyout = 1'b1;
    read_val = 8'h00;

    // data phase of a write; bits outside the mask keep their value
    if (s.ahb_wr) begin
      case (s.ahb_sel)
        sel_cfg_one: begin
          next_s.cfg_one = (s.cfg_one & ~cfg_one_wmask) | (hwdata[7:0] & cfg_one_wmask);
        end
        sel_cfg_two: begin
          next_s.cfg_two = (s.cfg_two & ~cfg_two_wmask) | (hwdata[7:0] & cfg_two_wmask);
        end
        sel_ctrl: begin
          next_s.ctrl = (s.ctrl & ~bus_ctrl_wmask) | (hwdata[7:0] & bus_ctrl_wmask);
        end
        default: begin
        end
      endcase
    end

    // address phase; reads see a write still in its data phase
    next_s.ahb_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_s.ahb_wr = hwrite;
      next_s.ahb_sel = dec_sel;
      case (dec_sel)
        sel_cfg_one: read_val = next_s.cfg_one;
        sel_cfg_two: read_val = next_s.cfg_two;
        sel_ctrl: read_val = next_s.ctrl;
        sel_status: read_val = status_val;
        default: read_val = 8'h00;
      endcase
      if (!hwrite) begin
        next_s.hrdata = {24'h0, read_val};
      end
    end

    // memory cycle sequencer
    case (s.phase)
      ph_idle: begin
        if (hold_en && !hold_request_in_n) begin
          next_s.phase = ph_hold;
        end else if (req) begin
          next_s.phase = ph_t1;
          next_s.cnt = {1'b0, stretch_sel};
          next_s.acc_write = req_write;
          next_s.acc_lower = !req_addr[block_select_bit];
          next_s.acc_ext = !req_internal;
          // internal cycles drive the pins only when asked and unprotected
          next_s.acc_pins = !req_internal ||
              (s.cfg_one[pin_toggle_select_bit] && !mem_protect);
          if (next_s.acc_pins) begin
            next_s.as_core = 1'b0;
            next_s.rw_level = !req_write;
            next_s.p0_out = req_addr[7:0];
            next_s.p0_drive = 1'b1;
            next_s.p1_out = req_addr[15:8];
          end
          next_s.rdata = req_wdata;
        end
      end
      ph_t1: begin
        if (wait_hit) begin
          next_s.phase = ph_t1;
        end else if (s.cnt != 3'h0) begin
          next_s.cnt = s.cnt - 3'h1;
        end else begin
          next_s.phase = ph_t2;
          next_s.as_core = 1'b1;
          // data strobes never move on internal cycles
          next_s.ds_core = !s.acc_ext;
          if (s.acc_pins) begin
            next_s.p0_drive = s.acc_write;
            if (s.acc_write) begin
              next_s.p0_out = s.rdata;
            end
          end
        end
      end
      ph_t2: begin
        if (!wait_hit) begin
          next_s.done = 1'b1;
          next_s.ds_core = 1'b1;
          if (!s.acc_write) begin
            next_s.rdata = low_port_in;
          end
          // request sampled at the close of t2
          if (hold_en && !hold_request_in_n) begin
            next_s.phase = ph_hold;
          end else begin
            next_s.phase = ph_idle;
          end
        end
      end
      ph_hold: begin
        if (hold_request_in_n || !hold_en) begin
          next_s.phase = ph_idle;
        end
      end
      default: begin
        next_s.phase = ph_idle;
      end
    endcase

    // pin mapping from the legacy strobe levels
    released = (next_s.phase == ph_hold) || next_s.ctrl[bus_float_bit];
    next_s.as_out = next_s.cfg_one[strobe_style_bit] ?
        !next_s.as_core : next_s.as_core;
    if (next_s.cfg_one[lower_strobe_enable_bit] && next_s.acc_lower) begin
      next_s.ds_out = 1'b1;
      next_s.ds2_out = (next_s.cfg_one[strobe_style_bit] && next_s.acc_write) ?
          1'b1 : next_s.ds_core;
    end else begin
      next_s.ds_out = (next_s.cfg_one[strobe_style_bit] && next_s.acc_write) ?
          1'b1 : next_s.ds_core;
      next_s.ds2_out = 1'b1;
    end
    if (next_s.cfg_one[strobe_style_bit]) begin
      next_s.rw_out = next_s.acc_write ? next_s.ds_core : 1'b1;
    end else begin
      next_s.rw_out = next_s.rw_level;
    end
    next_s.strobe_oe = !released;
    next_s.as_oe = !released && next_s.cfg_one[addr_strobe_pin_alt_bit];
    next_s.p0_oe = !released && next_s.p0_drive;
    next_s.p1_oe = !released;
    next_s.hold_ack_n = next_s.phase != ph_hold;
  end

  // style one idles with the address latch pulse low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{phase: ph_idle, cnt: 3'h0, acc_write: 1'b0, acc_lower: 1'b0,
             acc_ext: 1'b0, acc_pins: 1'b0, cfg_one: cfg_one_reset,
             cfg_two: cfg_two_reset, ctrl: bus_ctrl_reset, ahb_wr: 1'b0,
             ahb_sel: sel_none, hrdata: 32'h0, hreadyout: 1'b1, done: 1'b0,
             rdata: 8'h00, as_core: 1'b1, ds_core: 1'b1, rw_level: 1'b1,
             as_out: 1'b1, as_oe: 1'b0, ds_out: 1'b1, ds2_out: 1'b1,
             rw_out: 1'b1, strobe_oe: 1'b1, p0_out: 8'h00, p0_drive: 1'b0,
             p0_oe: 1'b0, p1_out: 8'h00, p1_oe: 1'b1, hold_ack_n: 1'b1};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign done = s.done;
  assign rdata = s.rdata;
  assign address_strobe_out = s.as_out;
  assign address_strobe_oe = s.as_oe;
  assign data_strobe_out = s.ds_out;
  assign data_strobe_oe = s.strobe_oe;
  assign lower_block_strobe = s.ds2_out;
  assign lower_block_strobe_oe = s.strobe_oe;
  assign rw_out = s.rw_out;
  assign rw_oe = s.strobe_oe;
  assign low_port_out = s.p0_out;
  assign low_port_oe = s.p0_oe;
  assign high_port_out = s.p1_out;
  assign high_port_oe = s.p1_oe;
  assign hold_ack_n = s.hold_ack_n;
  assign drive_strength = s.cfg_one[drive_strength_bit];
  assign segment_save_enable = s.cfg_two[segment_save_enable_bit];
  assign page_reg_swap = s.cfg_two[page_reg_swap_bit];

  // checks
  property p_rw_level;
    @(posedge hclk) disable iff (!hresetn)
      (ce && s.phase == ph_idle && req && !(hold_en && !hold_request_in_n) &&
       !req_internal && !style)
      |=> (rw_out == !$past(req_write)) && (s.phase == ph_t1);
  endproperty
  a_rw_level: assert property (p_rw_level) else $error("rw level wrong");

  property p_float;
    @(posedge hclk) disable iff (!hresetn)
      (s.phase == ph_hold || s.ctrl[bus_float_bit]) |->
      !rw_oe && !data_strobe_oe && !address_strobe_oe;
  endproperty
  a_float: assert property (p_float) else $error("strobe driven while released");

  property p_hold_enter;
    @(posedge hclk) disable iff (!hresetn)
      (ce && s.phase == ph_t2 && !wait_hit && hold_en && !hold_request_in_n)
      |=> s.phase == ph_hold && !low_port_oe && !high_port_oe;
  endproperty
  a_hold_enter: assert property (p_hold_enter) else $error("hold not taken");

  property p_hold_leave;
    @(posedge hclk) disable iff (!hresetn)
      (ce && s.phase == ph_hold && hold_request_in_n) |=> s.phase == ph_idle;
  endproperty
  a_hold_leave: assert property (p_hold_leave) else $error("hold not left");

  property p_ack;
    @(posedge hclk) disable iff (!hresetn)
      !hold_ack_n |-> !high_port_oe && !rw_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("ack while driving");

  property p_wait;
    @(posedge hclk) disable iff (!hresetn)
      (ce && s.phase == ph_t2 && wait_hit) |=> s.phase == ph_t2 && !done;
  endproperty
  a_wait: assert property (p_wait) else $error("wait not honoured");

  property p_stretch;
    @(posedge hclk) disable iff (!hresetn)
      (ce && s.phase == ph_t1 && s.cnt == 3'h2 && !wait_hit) ##1 (ce && !wait_hit)
      |=> s.phase == ph_t1 ##1 (!$past(ce) || $past(wait_hit) || s.phase == ph_t2);
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch count off");

  property p_ds2_off;
    @(posedge hclk) disable iff (!hresetn)
      !s.cfg_one[lower_strobe_enable_bit] |-> lower_block_strobe;
  endproperty
  a_ds2_off: assert property (p_ds2_off) else $error("lower strobe moved");

  property p_oen_write;
    @(posedge hclk) disable iff (!hresetn)
      (style && s.acc_write) |-> data_strobe_out && lower_block_strobe;
  endproperty
  a_oen_write: assert property (p_oen_write) else $error("read enable on write");

  c_read: cover property (@(posedge hclk) s.phase == ph_t2 && !s.acc_write ##1 done);
  c_write: cover property (@(posedge hclk) s.phase == ph_t2 && s.acc_write ##1 done);
  c_hold: cover property (@(posedge hclk) s.phase == ph_hold ##1 s.phase == ph_idle);
  c_wait: cover property (@(posedge hclk) s.phase == ph_t1 && wait_hit);

endmodule

// ==== test/ext_mem_model.sv ====
// behavioural external memory and bus requester on the far side of the interface
// assumes pins are sampled on hclk rising edges; strobes active low, style selects latch polarity
`timescale 1ns/1ps

module ext_mem_model (
  // clock and settings from the bench
  input wire logic hclk,
  input wire logic style,
  input wire logic [3:0] wait_len,
  input wire logic wait_data,
  input wire logic hold_req,
  // strobes
  input wire logic address_strobe_out,
  input wire logic address_strobe_oe,
  input wire logic data_strobe_out,
  input wire logic data_strobe_oe,
  input wire logic lower_block_strobe,
  input wire logic lower_block_strobe_oe,
  input wire logic rw_out,
  input wire logic rw_oe,
  // ports
  input wire logic [7:0] low_port_out,
  input wire logic low_port_oe,
  input wire logic [7:0] high_port_out,
  input wire logic high_port_oe,
  output logic [7:0] low_port_in,
  output logic wait_n,
  output logic hold_request_in_n
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_lat = 16'h0000;
  logic [7:0] last = 8'h00;
  logic [3:0] t1_cnt = 4'h0;
  logic as_act, ds_act, rd, we;
  logic wait_on;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
    end
  end

  assign as_act = address_strobe_oe && (address_strobe_out == style);
  assign ds_act = (data_strobe_oe && !data_strobe_out) || (lower_block_strobe_oe && !lower_block_strobe);
  assign rd = !low_port_oe && ds_act;
  assign we = low_port_oe && rw_oe && !rw_out && (style || ds_act);
  // released port shows the inverse of the last value, not a stale copy
  assign low_port_in = rd ? mem[addr_lat] : ~last;
  // wait held low for the first wait_len samples of address or data phase
  assign wait_on = wait_data ? ds_act : as_act;
  assign wait_n = !(wait_on && (t1_cnt < wait_len));
  assign hold_request_in_n = !hold_req;

  always @(posedge hclk) begin
    if (as_act && high_port_oe && low_port_oe) begin
      addr_lat <= {high_port_out, low_port_out};
    end
    t1_cnt <= wait_on ? t1_cnt + 4'h1 : 4'h0;
    if (rd) begin
      last <= mem[addr_lat];
    end
    if (we) begin
      mem[addr_lat] <= low_port_out;
    end
  end
endmodule

// ==== test/external_memory_bus_interface_tb.sv ====
// register and external access tests for the external memory bus interface
// assumes the far side is the behavioural memory model; one ahb-lite slave on the bus
`timescale 1ns/1ps

module external_memory_bus_interface_tb;
  import ext_mem_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, req = 0, req_write = 0, req_internal = 0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [21:0] req_addr = 22'h0;
  logic [7:0] req_wdata = 8'h0, rdata, low_port_in, low_port_out, high_port_out;
  logic hold_pins_alt = 0, hold_req = 0, style = 0, wait_data = 0, mem_protect = 0;
  logic [3:0] wait_len = 4'h0;
  logic hreadyout, hresp, done, address_strobe_out, address_strobe_oe, data_strobe_out;
  logic data_strobe_oe, lower_block_strobe, lower_block_strobe_oe, rw_out, rw_oe;
  logic low_port_oe, high_port_oe, wait_n, hold_request_in_n, hold_ack_n;
  logic drive_strength, segment_save_enable, page_reg_swap, ds_lo, ds2_lo, rw_lo;
  int err_count = 0, num_checks = 0, cyc = 0, n, as_cnt;

  external_memory_bus_interface external_memory_bus_interface_inst (
    .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .req, .req_write, .req_internal,
    .req_addr, .req_wdata, .done, .rdata, .hold_pins_alt, .mem_protect,
    .address_strobe_out, .address_strobe_oe, .data_strobe_out, .data_strobe_oe,
    .lower_block_strobe, .lower_block_strobe_oe, .rw_out, .rw_oe, .low_port_in,
    .low_port_out, .low_port_oe, .high_port_out, .high_port_oe, .wait_n,
    .hold_request_in_n, .hold_ack_n, .drive_strength, .segment_save_enable, .page_reg_swap
  );

  ext_mem_model ext_mem_model_inst (
    .hclk, .style, .wait_len, .wait_data, .hold_req, .address_strobe_out, .address_strobe_oe,
    .data_strobe_out, .data_strobe_oe, .lower_block_strobe, .lower_block_strobe_oe,
    .rw_out, .rw_oe, .low_port_out, .low_port_oe, .high_port_out, .high_port_oe,
    .low_port_in, .wait_n, .hold_request_in_n
  );

  always #10 hclk = ~hclk;

  // strobe activity seen while a core access is open
  always @(posedge hclk) begin
    if (req) begin
      if (data_strobe_oe && !data_strobe_out) ds_lo = 1;
      if (lower_block_strobe_oe && !lower_block_strobe) ds2_lo = 1;
      if (rw_oe && !rw_out) rw_lo = 1;
      if (address_strobe_oe && address_strobe_out == style) as_cnt++;
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tdone(input string s);
    $display("test %s finished", s);
  endtask

  function automatic logic [31:0] exp_rd(input logic [15:0] a);
    return {24'h0, a[7:0] ^ a[15:8] ^ 8'h5a};
  endfunction

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // latency n-1 counts edges from the taking edge to the done pulse
  task automatic core(input logic w, input logic intl, input logic [21:0] a, input logic [7:0] d);
    @(posedge hclk);
    req <= 1'b1;
    req_write <= w;
    req_internal <= intl;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
      // pins at the taking edge still belong to the previous cycle
      if (n == 1) begin
        ds_lo = 0;
        ds2_lo = 0;
        rw_lo = 0;
        as_cnt = 0;
      end
    end while (done !== 1'b1 && n < 60);
    // dropped before the next edge so no second cycle starts
    req <= 1'b0;
    @(posedge hclk);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(cfg_one_addr, 32'h80);
    rdchk(cfg_two_addr, 32'h1f);
    rdchk(bus_ctrl_addr, 32'h0);
    chk(address_strobe_oe, 1'b0);
    wr(32'h400, 32'hff);
    rdchk(32'h400, 32'h0);
    wr(cfg_one_addr, 32'hff);
    rdchk(cfg_one_addr, 32'hf6);
    chk(drive_strength, 1'b1);
    wr(cfg_two_addr, 32'hff);
    rdchk(cfg_two_addr, 32'h7f);
    chk({segment_save_enable, page_reg_swap}, 2'b11);
    wr(cfg_two_addr, 32'h10);
    wr(cfg_one_addr, 32'h10);
    rdchk(cfg_one_addr, 32'h90);
    chk({address_strobe_oe, drive_strength, segment_save_enable}, 3'b100);
    tdone("registers");
    core(1'b0, 1'b0, 22'h001234, 8'h0);
    chk(n - 1, 2);
    chk(rdata, exp_rd(16'h1234));
    chk(ext_mem_model_inst.addr_lat, 16'h1234);
    chk({rw_lo, ds_lo, ds2_lo, 8'(as_cnt)}, {3'b010, 8'd1});
    core(1'b1, 1'b0, 22'h200a0b, 8'ha5);
    chk(ext_mem_model_inst.mem[16'h0a0b], 8'ha5);
    chk({rw_lo, ds_lo}, 2'b11);
    tdone("access");
    wr(cfg_two_addr, 32'h1e);
    core(1'b0, 1'b0, 22'h000777, 8'h0);
    chk(n - 1, 5);
    chk(as_cnt, 4);
    core(1'b0, 1'b0, 22'h200777, 8'h0);
    chk(n - 1, 4);
    wr(cfg_two_addr, 32'h10);
    wait_len <= 4'h2;
    core(1'b0, 1'b0, 22'h0001ff, 8'h0);
    chk(n - 1, 2);
    wr(bus_ctrl_addr, 32'h4);
    core(1'b0, 1'b0, 22'h0001ff, 8'h0);
    chk(n - 1, 4);
    chk(as_cnt, 3);
    chk(rdata, exp_rd(16'h01ff));
    // same two waits, now taken in the data phase
    wait_data <= 1'b1;
    core(1'b0, 1'b0, 22'h0001ff, 8'h0);
    chk({8'(n - 1), 8'(as_cnt)}, {8'd4, 8'd1});
    chk(rdata, exp_rd(16'h01ff));
    wait_data <= 1'b0;
    wait_len <= 4'h0;
    wr(bus_ctrl_addr, 32'h0);
    tdone("stretch and wait");
    style <= 1'b1;
    wr(cfg_one_addr, 32'h50);
    core(1'b1, 1'b0, 22'h200102, 8'h3c);
    chk({ds_lo, rw_lo, 8'(as_cnt)}, {2'b01, 8'd1});
    chk(ext_mem_model_inst.mem[16'h0102], 8'h3c);
    core(1'b0, 1'b0, 22'h200102, 8'h0);
    chk({ds_lo, rw_lo}, 2'b10);
    chk(rdata, 8'h3c);
    style <= 1'b0;
    wr(cfg_one_addr, 32'h30);
    core(1'b0, 1'b0, 22'h000456, 8'h0);
    chk({ds_lo, ds2_lo}, 2'b01);
    chk(rdata, exp_rd(16'h0456));
    core(1'b0, 1'b0, 22'h200456, 8'h0);
    chk({ds_lo, ds2_lo}, 2'b10);
    core(1'b0, 1'b1, 22'h000456, 8'h0);
    chk({ds_lo, ds2_lo, rw_lo, 8'(as_cnt)}, 11'h0);
    wr(cfg_one_addr, 32'h34);
    core(1'b0, 1'b1, 22'h000456, 8'h0);
    chk({ds_lo, ds2_lo, 8'(as_cnt)}, {2'b00, 8'd1});
    mem_protect <= 1'b1;
    core(1'b0, 1'b1, 22'h000456, 8'h0);
    chk(8'(as_cnt), 8'd0);
    mem_protect <= 1'b0;
    wr(cfg_one_addr, 32'h10);
    tdone("strobe modes");
    wr(bus_ctrl_addr, 32'h1);
    rdchk(bus_ctrl_addr, 32'h1);
    chk(rw_oe, 1'b0);
    wr(bus_ctrl_addr, 32'h0);
    @(posedge hclk);
    hold_pins_alt <= 1'b1;
    hold_req <= 1'b1;
    repeat (5) @(posedge hclk);
    #1;
    chk(hold_ack_n, 1'b1);
    wr(bus_ctrl_addr, 32'h2);
    repeat (3) @(posedge hclk);
    #1;
    chk(hold_ack_n, 1'b0);
    chk({rw_oe, data_strobe_oe, lower_block_strobe_oe}, 3'b000);
    chk({low_port_oe, high_port_oe, address_strobe_oe}, 3'b000);
    @(posedge hclk);
    hold_req <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk({hold_ack_n, high_port_oe, rw_oe}, 3'b111);
    core(1'b0, 1'b0, 22'h003344, 8'h0);
    chk(rdata, exp_rd(16'h3344));
    // request raised while the access is in t2; bus yields as t2 closes
    fork
      core(1'b0, 1'b0, 22'h003344, 8'h0);
      begin
        repeat (3) @(posedge hclk);
        hold_req <= 1'b1;
      end
    join
    chk({hold_ack_n, low_port_oe, high_port_oe}, 3'b000);
    chk(rdata, exp_rd(16'h3344));
    hold_req <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk(hold_ack_n, 1'b1);
    tdone("float and hold");
    end_sim();
  end
endmodule
